// ===== twi_regs_pkg.sv
// constants, layouts and types of the two-wire master register bank
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
package twi_regs_pkg;

  // ----------------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [11:0] OFS_IRQ_ENABLE = 12'h300;
  localparam logic [11:0] OFS_IRQ_ENABLE_SET = 12'h304;
  localparam logic [11:0] OFS_IRQ_ENABLE_CLEAR = 12'h308;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h310;
  localparam logic [11:0] OFS_ERROR_SOURCE = 12'h4c4;
  localparam logic [11:0] OFS_MASTER_ENABLE = 12'h500;
  localparam logic [11:0] OFS_BUS_RATE = 12'h524;
  localparam logic [11:0] OFS_TARGET_ADDRESS = 12'h588;
  localparam logic [11:0] OFS_CLOCK_LINE_PIN = 12'h600;
  localparam logic [11:0] OFS_DATA_LINE_PIN = 12'h604;
  localparam logic [11:0] OFS_RX_BUFFER_POINTER = 12'h704;
  localparam logic [11:0] OFS_RX_BUFFER_LIMIT = 12'h708;
  localparam logic [11:0] OFS_RX_BYTES_MOVED = 12'h70c;
  localparam logic [11:0] OFS_RX_ABORT_ON_FAULT = 12'h71c;
  localparam logic [11:0] OFS_RX_FAULT_ADDRESS = 12'h720;

  // ----------------------------------------------------------------------
  // event bit positions, shared by enable and status registers
  // ----------------------------------------------------------------------
  localparam int BIT_STOPPED = 1;
  localparam int BIT_ERROR = 5;
  localparam int BIT_SUSPENDED = 10;
  localparam int BIT_FINAL_RX = 13;
  localparam int BIT_FINAL_TX = 14;
  localparam int BIT_RX_DONE = 19;
  localparam int BIT_RX_PRIMED = 20;
  localparam int BIT_RX_FAULT = 21;
  localparam int BIT_RX_HIT0 = 22;
  localparam int BIT_TX_DONE = 26;
  localparam int BIT_TX_PRIMED = 27;
  localparam int BIT_TX_FAULT = 28;

  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [2:0] ERROR_SOURCE_MASK = 3'h7;
  localparam int MASTER_ON_BIT = 0;
  localparam int ABORT_ON_BIT = 0;
  localparam logic [15:0] RATE_MIN = 16'h0001;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic stopped;
    logic error;
    logic suspended;
    logic finalByteReceived;
    logic finalByteSent;
    logic rxDmaDone;
    logic rxDmaPrimed;
    logic rxDmaFault;
    logic [3:0] rxPatternHit;
    logic txDmaDone;
    logic txDmaPrimed;
    logic txDmaFault;
  } twi_events_s;

  typedef enum logic [1:0] {PH_IDLE, PH_WAIT, PH_DONE} bus_phase_e;

endpackage

// ===== twi_master_irq_and_dma_regs.sv
// register bank, interrupt logic and bus clock divider of the two-wire master
`timescale 1ns/10ps
module twi_master_irq_and_dma_regs (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // events and data from the sequencer and dma engine
  input wire twi_regs_pkg::twi_events_s evIn,
  input wire logic [2:0] errorFlags,
  input wire logic [31:0] dmaCount,
  input wire logic [31:0] dmaFaultAddr,
  input wire logic linkRun,
  // settings toward the sequencer and dma engine
  output logic masterOn,
  output logic [31:0] rxBufferPointer,
  output logic [31:0] rxBufferLimit,
  output logic [31:0] targetAddress,
  output logic [31:0] clockLinePin,
  output logic [31:0] dataLinePin,
  output logic rxAbort,
  output logic irq,
  // bus clock line, open drain
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] eventWord(twi_regs_pkg::twi_events_s e);
    logic [31:0] w;
    w = twi_regs_pkg::RESET_WORD;
    w[twi_regs_pkg::BIT_STOPPED] = e.stopped;
    w[twi_regs_pkg::BIT_ERROR] = e.error;
    w[twi_regs_pkg::BIT_SUSPENDED] = e.suspended;
    w[twi_regs_pkg::BIT_FINAL_RX] = e.finalByteReceived;
    w[twi_regs_pkg::BIT_FINAL_TX] = e.finalByteSent;
    w[twi_regs_pkg::BIT_RX_DONE] = e.rxDmaDone;
    w[twi_regs_pkg::BIT_RX_PRIMED] = e.rxDmaPrimed;
    w[twi_regs_pkg::BIT_RX_FAULT] = e.rxDmaFault;
    w[twi_regs_pkg::BIT_RX_HIT0 +: 4] = e.rxPatternHit;
    w[twi_regs_pkg::BIT_TX_DONE] = e.txDmaDone;
    w[twi_regs_pkg::BIT_TX_PRIMED] = e.txDmaPrimed;
    w[twi_regs_pkg::BIT_TX_FAULT] = e.txDmaFault;
    return w;
  endfunction

  // valid positions only, so reserved bits stay zero
  localparam logic [31:0] EVENT_MASK = eventWord('1);

  function automatic logic [15:0] halfPeriod(logic [31:0] rate);
    return (rate[15:0] < twi_regs_pkg::RATE_MIN) ? twi_regs_pkg::RATE_MIN : rate[15:0];
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  twi_regs_pkg::bus_phase_e phase_reg;
  logic [11:0] addr_reg;
  logic write_reg;
  logic [31:0] irqEnable_reg;
  logic [31:0] irqStatus_reg;
  logic [2:0] errorSource_reg;
  logic [31:0] masterEnable_reg;
  logic [31:0] busRate_reg;
  logic [31:0] rxBytesMoved_reg;
  logic [31:0] abortOnFault_reg;
  logic [31:0] rxFaultAddress_reg;
  logic sclMeta_reg;
  logic sclSync_reg;
  logic sclPrev_reg;
  logic [15:0] phaseCnt_reg;
  logic [31:0] evBits;
  logic accept;
  logic doWrite;

  assign evBits = eventWord(evIn);
  assign accept = hsel && htrans[1] && hready;
  assign doWrite = (phase_reg == twi_regs_pkg::PH_WAIT) && write_reg;

  // ----------------------------------------------------------------------
  // ahb-lite slave: one wait state so read data leaves a flop
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      phase_reg <= twi_regs_pkg::PH_IDLE;
      addr_reg <= 12'h000;
      write_reg <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      case (phase_reg)
        twi_regs_pkg::PH_WAIT: begin
          phase_reg <= twi_regs_pkg::PH_DONE;
          hreadyout <= 1'b1;
        end
        twi_regs_pkg::PH_IDLE, twi_regs_pkg::PH_DONE: begin
          if (accept) begin
            phase_reg <= twi_regs_pkg::PH_WAIT;
            addr_reg <= {haddr[11:2], 2'b00};
            write_reg <= hwrite;
            hreadyout <= 1'b0;
          end else begin
            phase_reg <= twi_regs_pkg::PH_IDLE;
            write_reg <= 1'b0;
            hreadyout <= 1'b1;
          end
        end
        default: begin
          phase_reg <= twi_regs_pkg::PH_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  // unmapped offsets read zero
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      hrdata <= twi_regs_pkg::RESET_WORD;
    end else if (phase_reg == twi_regs_pkg::PH_WAIT && !write_reg) begin
      case (addr_reg)
        twi_regs_pkg::OFS_IRQ_ENABLE,
        twi_regs_pkg::OFS_IRQ_ENABLE_SET,
        twi_regs_pkg::OFS_IRQ_ENABLE_CLEAR: hrdata <= irqEnable_reg;
        twi_regs_pkg::OFS_IRQ_STATUS: hrdata <= irqStatus_reg;
        twi_regs_pkg::OFS_ERROR_SOURCE: hrdata <= {29'h0, errorSource_reg};
        twi_regs_pkg::OFS_MASTER_ENABLE: hrdata <= masterEnable_reg;
        twi_regs_pkg::OFS_BUS_RATE: hrdata <= busRate_reg;
        twi_regs_pkg::OFS_TARGET_ADDRESS: hrdata <= targetAddress;
        twi_regs_pkg::OFS_CLOCK_LINE_PIN: hrdata <= clockLinePin;
        twi_regs_pkg::OFS_DATA_LINE_PIN: hrdata <= dataLinePin;
        twi_regs_pkg::OFS_RX_BUFFER_POINTER: hrdata <= rxBufferPointer;
        twi_regs_pkg::OFS_RX_BUFFER_LIMIT: hrdata <= rxBufferLimit;
        twi_regs_pkg::OFS_RX_BYTES_MOVED: hrdata <= rxBytesMoved_reg;
        twi_regs_pkg::OFS_RX_ABORT_ON_FAULT: hrdata <= abortOnFault_reg;
        twi_regs_pkg::OFS_RX_FAULT_ADDRESS: hrdata <= rxFaultAddress_reg;
        default: hrdata <= twi_regs_pkg::RESET_WORD;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // interrupt enables, status and request
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      irqEnable_reg <= twi_regs_pkg::RESET_WORD;
    end else if (doWrite) begin
      case (addr_reg)
        twi_regs_pkg::OFS_IRQ_ENABLE: irqEnable_reg <= hwdata & EVENT_MASK;
        twi_regs_pkg::OFS_IRQ_ENABLE_SET: irqEnable_reg <= irqEnable_reg | (hwdata & EVENT_MASK);
        twi_regs_pkg::OFS_IRQ_ENABLE_CLEAR: irqEnable_reg <= irqEnable_reg & ~hwdata;
        default: irqEnable_reg <= irqEnable_reg;
      endcase
    end
  end

  // an event in the clearing cycle survives the clear
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      irqStatus_reg <= twi_regs_pkg::RESET_WORD;
    end else if (doWrite && addr_reg == twi_regs_pkg::OFS_IRQ_STATUS) begin
      irqStatus_reg <= (irqStatus_reg & ~hwdata) | (evBits & EVENT_MASK);
    end else begin
      irqStatus_reg <= irqStatus_reg | (evBits & EVENT_MASK);
    end
  end

  // disabling drops the request but keeps the flag
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatus_reg & irqEnable_reg);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      errorSource_reg <= 3'h0;
    end else if (doWrite && addr_reg == twi_regs_pkg::OFS_ERROR_SOURCE) begin
      errorSource_reg <= (errorSource_reg & ~hwdata[2:0]) | errorFlags;
    end else begin
      errorSource_reg <= (errorSource_reg | errorFlags) & twi_regs_pkg::ERROR_SOURCE_MASK;
    end
  end

  // ----------------------------------------------------------------------
  // plain configuration registers
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      masterEnable_reg <= twi_regs_pkg::RESET_WORD;
      busRate_reg <= twi_regs_pkg::RESET_WORD;
      targetAddress <= twi_regs_pkg::RESET_WORD;
      clockLinePin <= twi_regs_pkg::RESET_WORD;
      dataLinePin <= twi_regs_pkg::RESET_WORD;
      rxBufferPointer <= twi_regs_pkg::RESET_WORD;
      rxBufferLimit <= twi_regs_pkg::RESET_WORD;
      abortOnFault_reg <= twi_regs_pkg::RESET_WORD;
    end else if (doWrite) begin
      case (addr_reg)
        twi_regs_pkg::OFS_MASTER_ENABLE: masterEnable_reg <= hwdata;
        twi_regs_pkg::OFS_BUS_RATE: busRate_reg <= hwdata;
        twi_regs_pkg::OFS_TARGET_ADDRESS: targetAddress <= hwdata;
        twi_regs_pkg::OFS_CLOCK_LINE_PIN: clockLinePin <= hwdata;
        twi_regs_pkg::OFS_DATA_LINE_PIN: dataLinePin <= hwdata;
        twi_regs_pkg::OFS_RX_BUFFER_POINTER: rxBufferPointer <= hwdata;
        twi_regs_pkg::OFS_RX_BUFFER_LIMIT: rxBufferLimit <= hwdata;
        twi_regs_pkg::OFS_RX_ABORT_ON_FAULT: abortOnFault_reg <= hwdata;
        default: masterEnable_reg <= masterEnable_reg;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      masterOn <= 1'b0;
    end else begin
      masterOn <= masterEnable_reg[twi_regs_pkg::MASTER_ON_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // receive dma status
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rxBytesMoved_reg <= twi_regs_pkg::RESET_WORD;
    end else if (evIn.rxDmaDone || (|evIn.rxPatternHit)) begin
      rxBytesMoved_reg <= dmaCount;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rxFaultAddress_reg <= twi_regs_pkg::RESET_WORD;
    end else if (evIn.rxDmaFault) begin
      rxFaultAddress_reg <= dmaFaultAddr;
    end
  end

  // one-cycle abort pulse toward the sequencer
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rxAbort <= 1'b0;
    end else begin
      rxAbort <= evIn.rxDmaFault && abortOnFault_reg[twi_regs_pkg::ABORT_ON_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // bus clock divider with stretch detection
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      sclMeta_reg <= 1'b1;
      sclSync_reg <= 1'b1;
      sclPrev_reg <= 1'b1;
    end else begin
      sclMeta_reg <= sclIn;
      sclSync_reg <= sclMeta_reg;
      sclPrev_reg <= sclSync_reg;
    end
  end

  // a slave holding the line low stretches the high phase, not the count
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      phaseCnt_reg <= 16'h0000;
      sclOe <= 1'b0;
      sclOut <= 1'b0;
    end else if (!(masterOn && linkRun)) begin
      phaseCnt_reg <= 16'h0000;
      sclOe <= 1'b0;
    end else if (!sclOe && !sclSync_reg) begin
      phaseCnt_reg <= 16'h0000;
    end else if (phaseCnt_reg + 16'h0001 >= halfPeriod(busRate_reg)) begin
      phaseCnt_reg <= 16'h0000;
      sclOe <= !sclOe;
    end else begin
      phaseCnt_reg <= phaseCnt_reg + 16'h0001;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_enable_set_write: assert property (
    doWrite && addr_reg == twi_regs_pkg::OFS_IRQ_ENABLE_SET
    |=> (irqEnable_reg & $past(hwdata) & EVENT_MASK) == ($past(hwdata) & EVENT_MASK))
    else $error("enable set write did not enable bits");
  a_enable_clear_write: assert property (
    doWrite && addr_reg == twi_regs_pkg::OFS_IRQ_ENABLE_CLEAR
    |=> (irqEnable_reg & $past(hwdata)) == 32'h0)
    else $error("enable clear write left bits enabled");
  a_event_sets_status: assert property (
    evIn.txDmaFault |=> irqStatus_reg[twi_regs_pkg::BIT_TX_FAULT])
    else $error("event did not set status");
  a_irq_tracks_flags: assert property (
    evIn.rxDmaPrimed && irqEnable_reg[twi_regs_pkg::BIT_RX_PRIMED]
    && !doWrite |=> ##1 irq)
    else $error("enabled event raised no interrupt");
  a_irq_needs_enable: assert property (
    irq |-> $past(|(irqStatus_reg & irqEnable_reg)))
    else $error("interrupt without enabled flag");
  a_fault_addr_capture: assert property (
    evIn.rxDmaFault |=> rxFaultAddress_reg == $past(dmaFaultAddr))
    else $error("fault address not captured");
  a_moved_on_hit: assert property (
    (evIn.rxDmaDone || |evIn.rxPatternHit) |=> rxBytesMoved_reg == $past(dmaCount))
    else $error("moved count not refreshed");
  a_abort_on_fault: assert property (
    evIn.rxDmaFault && abortOnFault_reg[twi_regs_pkg::ABORT_ON_BIT] |=> rxAbort)
    else $error("fault with abort set did not abort");
  a_pointer_write: assert property (
    doWrite && addr_reg == twi_regs_pkg::OFS_RX_BUFFER_POINTER
    |=> rxBufferPointer == $past(hwdata))
    else $error("pointer write lost");
  a_bus_one_wait: assert property (
    accept |=> !hreadyout ##1 hreadyout)
    else $error("bus answer not after one wait state");
  a_limit_write: assert property (
    doWrite && addr_reg == twi_regs_pkg::OFS_RX_BUFFER_LIMIT
    |=> rxBufferLimit == $past(hwdata))
    else $error("limit write lost");
  a_target_write: assert property (
    doWrite && addr_reg == twi_regs_pkg::OFS_TARGET_ADDRESS
    |=> targetAddress == $past(hwdata))
    else $error("target address write lost");
  a_pin_select_write: assert property (
    doWrite && addr_reg == twi_regs_pkg::OFS_DATA_LINE_PIN
    |=> dataLinePin == $past(hwdata))
    else $error("data pin select write lost");
  a_rate_write: assert property (
    doWrite && addr_reg == twi_regs_pkg::OFS_BUS_RATE
    |=> busRate_reg == $past(hwdata))
    else $error("rate write lost");
  a_abort_when_off: assert property (
    evIn.rxDmaFault && !abortOnFault_reg[twi_regs_pkg::ABORT_ON_BIT] |=> !rxAbort)
    else $error("abort raised with abort control off");
  a_disable_keeps_flag: assert property (
    doWrite && addr_reg == twi_regs_pkg::OFS_IRQ_ENABLE_CLEAR
    |=> (irqStatus_reg & $past(irqStatus_reg)) == $past(irqStatus_reg))
    else $error("disabling an event cleared its flag");
  a_status_set_wins: assert property (
    doWrite && addr_reg == twi_regs_pkg::OFS_IRQ_STATUS
    |=> (irqStatus_reg & $past(evBits) & EVENT_MASK) == ($past(evBits) & EVENT_MASK))
    else $error("event lost against status clear");

  c_irq_raised: cover property (irq);
  c_stretch_seen: cover property (sclOe ##1 !sclOe ##1 !sclSync_reg [*2]);
  c_abort_pulse: cover property (rxAbort);
  c_line_rise: cover property (sclSync_reg && !sclPrev_reg);
  c_status_cleared: cover property (doWrite && addr_reg == twi_regs_pkg::OFS_IRQ_STATUS);

endmodule // twi_master_irq_and_dma_regs

// ===== twi_slave_model.sv
// two-wire slave model on the bus clock line, with optional clock stretching
`timescale 1ns/10ps
module twi_slave_model (
  // clock
  input wire logic sys_clk,
  // master side of the clock line
  input wire logic sclOut,
  input wire logic sclOe,
  // stretch length in system cycles, zero for none
  input wire logic [7:0] stretchLen,
  // resolved line level
  output logic sclLine
);
  logic [7:0] lowCnt = 8'h00;
  logic hold;
  // --------------------------------------------------------------
  // cycles since the master released the line
  // --------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sclOe) begin
      lowCnt <= 8'h00;
    end else if (lowCnt != 8'hff) begin
      lowCnt <= lowCnt + 8'h01;
    end
  end
  // hold starts in the very first released cycle, so no high glitch
  assign hold = (!sclOe) && (lowCnt < stretchLen);
  // pull-up: line high unless someone pulls it low
  assign sclLine = ((sclOe && !sclOut) || hold) ? 1'b0 : 1'b1;
endmodule // twi_slave_model

// ===== twi_master_irq_and_dma_regs_test.sv
// self-checking testbench of the two-wire master register bank
`timescale 1ns/10ps
module twi_master_irq_and_dma_regs_test;
  // --------------------------------------------------------------
  // signals
  // --------------------------------------------------------------
  logic sys_clk, reset_n, hsel, hwrite, hreadyout, hresp, linkRun, masterOn;
  logic rxAbort, irq, sclIn, sclOut, sclOe;
  logic [31:0] haddr, hwdata, hrdata, dmaCount, dmaFaultAddr, rxBufferPointer;
  logic [31:0] rxBufferLimit, targetAddress, clockLinePin, dataLinePin;
  logic [1:0] htrans;
  logic [2:0] hsize, errorFlags;
  logic [7:0] stretchLen;
  twi_regs_pkg::twi_events_s evIn;
  int miscompares = 0;
  int checksDone = 0;
  int cycles = 0;
  // register bit of each event, in struct order from the top bit down
  int evBit[15] = '{1, 5, 10, 13, 14, 19, 20, 21, 25, 24, 23, 22, 26, 27, 28};

  twi_master_irq_and_dma_regs twi_master_irq_and_dma_regs_i (
    .sys_clk(sys_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .evIn(evIn),
    .errorFlags(errorFlags), .dmaCount(dmaCount), .dmaFaultAddr(dmaFaultAddr),
    .linkRun(linkRun), .masterOn(masterOn), .rxBufferPointer(rxBufferPointer),
    .rxBufferLimit(rxBufferLimit), .targetAddress(targetAddress),
    .clockLinePin(clockLinePin), .dataLinePin(dataLinePin), .rxAbort(rxAbort),
    .irq(irq), .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe));

  twi_slave_model twi_slave_model_i (.sys_clk(sys_clk), .sclOut(sclOut), .sclOe(sclOe),
    .stretchLen(stretchLen), .sclLine(sclIn));

  // --------------------------------------------------------------
  // clock and hang guard
  // --------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      complete_run;
    end
  end

  // --------------------------------------------------------------
  // compare, bus and event tasks
  // --------------------------------------------------------------
  task automatic cmp32(input string name, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cmpBit(input string name, input logic exp, input logic got);
    checksDone++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask
  // entered right after a rising edge; waits on hready, never on a fixed count
  task automatic xfer(input logic w, input logic [11:0] ofs, input logic [31:0] wd,
                      output logic [31:0] rdv);
    hsel <= 1'b1;
    haddr <= {20'h00000, ofs};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask
  task automatic wr(input logic [11:0] ofs, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, ofs, d, x);
  endtask
  task automatic rdc(input string name, input logic [11:0] ofs, input logic [31:0] exp);
    logic [31:0] x;
    xfer(1'b0, ofs, 32'h0000_0000, x);
    cmp32(name, exp, x);
  endtask
  task automatic pulse(input twi_regs_pkg::twi_events_s ev);
    evIn <= ev;
    @(posedge sys_clk);
    evIn <= '0;
  endtask
  task automatic wait_oe(input logic v, output int n);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (sclOe !== v && n < 200);
  endtask

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic test_reset;
    logic [11:0] ofs[6] = '{12'h304, 12'h308, 12'h310, 12'h70c, 12'h720, 12'h71c};
    foreach (ofs[i]) rdc("reset word", ofs[i], 32'h0000_0000);
    cmpBit("irq after reset", 1'b0, irq);
  endtask
  task automatic test_enables;
    logic [31:0] all = 32'h0000_0000;
    foreach (evBit[i]) all[evBit[i]] = 1'b1;
    wr(12'h304, 32'hffff_ffff);
    rdc("set reads enables", 12'h304, all);
    rdc("clear reads enables", 12'h308, all);
    wr(12'h308, 32'h0000_2022);
    rdc("partly cleared", 12'h304, all & ~32'h0000_2022);
    wr(12'h304, 32'h0000_0000);
    rdc("zero write ignored", 12'h308, all & ~32'h0000_2022);
    wr(12'h308, 32'hffff_ffff);
    rdc("all cleared", 12'h304, 32'h0000_0000);
    wr(12'h300, 32'hffff_ffff);
    rdc("whole enable word", 12'h300, all);
    wr(12'h300, 32'h0000_0000);
    rdc("whole enable cleared", 12'h304, 32'h0000_0000);
  endtask
  task automatic test_events;
    logic [31:0] m;
    for (int i = 0; i < 15; i++) begin
      m = 32'h0000_0001 << evBit[i];
      wr(12'h304, m);
      pulse(twi_regs_pkg::twi_events_s'(15'h0001 << (14 - i)));
      @(posedge sys_clk);
      cmpBit("irq too early", 1'b0, irq);
      @(posedge sys_clk);
      cmpBit("irq on enabled event", 1'b1, irq);
      wr(12'h308, m);
      @(posedge sys_clk);
      cmpBit("irq after disable", 1'b0, irq);
      rdc("event kept", 12'h310, m);
      wr(12'h310, m);
      rdc("event cleared", 12'h310, 32'h0000_0000);
    end
  endtask
  task automatic test_counts;
    twi_regs_pkg::twi_events_s ev;
    ev = '0;
    ev.rxDmaDone = 1'b1;
    dmaCount <= 32'h0000_0011;
    pulse(ev);
    rdc("moved at done", 12'h70c, 32'h0000_0011);
    ev = '0;
    ev.rxPatternHit = 4'h4;
    dmaCount <= 32'h0000_0005;
    pulse(ev);
    dmaCount <= 32'h0000_0099;
    rdc("moved at hit", 12'h70c, 32'h0000_0005);
    wr(12'h70c, 32'hffff_ffff);
    rdc("moved read only", 12'h70c, 32'h0000_0005);
    cmpBit("masked events quiet", 1'b0, irq);
    rdc("masked status", 12'h310, 32'h0108_0000);
    errorFlags <= 3'h5;
    @(posedge sys_clk);
    errorFlags <= 3'h0;
    rdc("error source sticky", 12'h4c4, 32'h0000_0005);
    wr(12'h4c4, 32'h0000_0001);
    rdc("error source cleared", 12'h4c4, 32'h0000_0004);
    wr(12'h310, 32'hffff_ffff);
  endtask
  task automatic test_fault;
    twi_regs_pkg::twi_events_s ev;
    ev = '0;
    ev.rxDmaFault = 1'b1;
    wr(12'h71c, 32'h0000_0001);
    dmaFaultAddr <= 32'h2000_0104;
    pulse(ev);
    @(posedge sys_clk);
    cmpBit("abort pulse", 1'b1, rxAbort);
    @(posedge sys_clk);
    cmpBit("abort one cycle", 1'b0, rxAbort);
    rdc("fault address", 12'h720, 32'h2000_0104);
    dmaFaultAddr <= 32'h2000_0ffc;
    wr(12'h71c, 32'h0000_0000);
    pulse(ev);
    @(posedge sys_clk);
    cmpBit("no abort when off", 1'b0, rxAbort);
    rdc("fault address newest", 12'h720, 32'h2000_0ffc);
    wr(12'h310, 32'hffff_ffff);
  endtask
  task automatic test_config;
    logic [11:0] ofs[6] = '{12'h524, 12'h588, 12'h600, 12'h604, 12'h704, 12'h708};
    logic [31:0] val[6] = '{32'h0000_0003, 32'h0000_0055, 32'h0000_001c, 32'h0000_001d,
                            32'h2000_0400, 32'h0000_00ff};
    foreach (ofs[i]) wr(ofs[i], val[i]);
    foreach (ofs[i]) rdc("config readback", ofs[i], val[i]);
    cmp32("target out", val[1], targetAddress);
    cmp32("clock pin out", val[2], clockLinePin);
    cmp32("data pin out", val[3], dataLinePin);
    cmp32("pointer out", val[4], rxBufferPointer);
    cmp32("limit out", val[5], rxBufferLimit);
    wr(12'h7fc, 32'hffff_ffff);
    rdc("unmapped reads zero", 12'h7fc, 32'h0000_0000);
    wr(12'h500, 32'h0000_0001);
    @(posedge sys_clk);
    cmpBit("master on", 1'b1, masterOn);
  endtask
  // rate 3: 30 ns driven low, 50 ns released (two sync cycles), an 80 ns link period
  task automatic test_bus_clock;
    int n;
    int base;
    int slow;
    linkRun <= 1'b1;
    wait_oe(1'b1, n);
    wait_oe(1'b0, n);
    cmp32("low phase", 32'd3, 32'(n));
    wait_oe(1'b1, base);
    stretchLen <= 8'd6;
    wait_oe(1'b0, n);
    wait_oe(1'b1, slow);
    cmp32("stretch added", 32'd6, 32'(slow - base));
    stretchLen <= 8'd0;
    linkRun <= 1'b0;
    repeat (12) @(posedge sys_clk);
    cmpBit("clock stopped", 1'b0, sclOe);
  endtask

  task automatic complete_run;
    $display("checks %0d miscompares %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    evIn = '0;
    errorFlags = 3'h0;
    dmaCount = 32'h0000_0000;
    dmaFaultAddr = 32'h0000_0000;
    linkRun = 1'b0;
    stretchLen = 8'h00;
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    test_reset;
    test_enables;
    test_events;
    test_counts;
    test_fault;
    test_config;
    test_bus_clock;
    complete_run;
  end
endmodule // twi_master_irq_and_dma_regs_test
